// *** ict_pkg.sv ***
// constants, encodings and timing figures for the instruction cycle timing model
package ict_pkg;

   // ******************************
   // widths
   // ******************************
   localparam int CLK_W = 10;                  // total clock count width
   localparam int RD_W  = 6;                   // read cycle count width
   localparam int WR_W  = 5;                   // write cycle count width
   localparam int OPD_W = 16;                  // multiply source operand width

   // ******************************
   // encodings
   // ******************************
   typedef enum logic [3:0] {
      OP_MOVE_LONG, OP_ADD, OP_AND, OP_OR, OP_SUB, OP_EXCL_OR, OP_COMPARE,
      OP_COMPARE_ADDR, OP_SMUL, OP_UMUL, OP_SDIV, OP_UDIV
   } ict_op_t;

   typedef enum logic [3:0] {
      M_DATA_REG, M_ADDR_REG, M_IND, M_POSTINC, M_PREDEC, M_DISP, M_INDEX,
      M_ABS_SHORT, M_ABS_LONG, M_PC_DISP, M_PC_INDEX, M_IMMEDIATE
   } ict_mode_t;

   typedef enum logic [1:0] {
      SZ_BYTE, SZ_WORD, SZ_LONG
   } ict_size_t;

   // ******************************
   // long move, source part (register destination), indexed by mode
   // ******************************
   localparam logic [11:0][6:0] MOVL_SRC_CLK = {
      7'd24, 7'd34, 7'd32, 7'd40, 7'd32, 7'd34, 7'd32, 7'd26, 7'd24, 7'd24, 7'd8, 7'd8};
   localparam logic [11:0][3:0] MOVL_SRC_RD = {
      4'd6, 4'd8, 4'd8, 4'd10, 4'd8, 4'd8, 4'd8, 4'd6, 4'd6, 4'd6, 4'd2, 4'd2};
   // long move, extra for the destination, indexed by mode
   localparam logic [11:0][5:0] MOVL_DST_CLK = {
      6'd0, 6'd0, 6'd0, 6'd32, 6'd24, 6'd26, 6'd24, 6'd16, 6'd16, 6'd16, 6'd0, 6'd0};
   localparam logic [11:0][2:0] MOVL_DST_RD = {
      3'd0, 3'd0, 3'd0, 3'd4, 3'd2, 3'd2, 3'd2, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0};
   localparam logic [11:0][2:0] MOVL_DST_WR = {
      3'd0, 3'd0, 3'd0, 3'd4, 3'd4, 3'd4, 3'd4, 3'd4, 3'd4, 3'd4, 3'd0, 3'd0};

   // ******************************
   // standard instruction figures
   // ******************************
   localparam logic [7:0] STD_REG_BW_CLK   = 8'd8;   // byte/word into a register
   localparam logic [7:0] STD_REG_L_CLK    = 8'd10;  // long into a register
   localparam logic [7:0] STD_REG_L_EXT    = 8'd12;  // long, register or immediate source
   localparam logic [7:0] EXCL_OR_L_CLK    = 8'd12;  // exclusive-or long into a register
   localparam logic [7:0] CMPA_CLK         = 8'd10;  // compare into address register
   localparam logic [7:0] MEM_B_CLK        = 8'd12;  // result to memory, byte
   localparam logic [7:0] MEM_W_CLK        = 8'd16;  // result to memory, word
   localparam logic [7:0] MEM_L_CLK        = 8'd24;  // result to memory, long
   localparam logic [3:0] MEM_B_WR         = 4'd1;
   localparam logic [3:0] MEM_W_WR         = 4'd2;
   localparam logic [3:0] MEM_L_WR         = 4'd4;
   localparam logic [3:0] STD_RD           = 4'd2;   // opcode and next prefetch
   localparam logic [7:0] SDIV_MAX_CLK     = 8'd162;
   localparam logic [7:0] UDIV_MAX_CLK     = 8'd144;
   localparam logic [7:0] MUL_BASE_CLK     = 8'd42;  // plus 2n, 74 at most

endpackage : ict_pkg

// *** ict_ones.sv ***
// counts the one bits of a vector
module ict_ones #(
   parameter int W = 16
) (
   input  wire logic [W-1:0]         vec,   // vector to count
   output logic      [$clog2(W+1)-1:0] count  // number of ones
);

   // ******************************
   // adder chain
   // ******************************
   // plain loop: the synthesiser builds the adder tree
   always_comb
   begin
      count = '0;
      for (int i = 0; i < W; i++)
      begin
         count = count + ($clog2(W+1))'(vec[i]);
      end
   end

endmodule // ict_ones

// *** ict_timing.sv ***
// cycle count calculator: clocks, read cycles and write cycles per instruction
//
// How it works
// - each answer is total clocks plus read count and write count
// - marked entries add the effective-address clocks, reads and writes
// - long moves: source part plus destination part, e.g. 8, 24, 72 clocks
// - indexed modes cost the same for word or long index register
// - standard counts already hold operation, store and next prefetch
// - add/and/or/sub: 8 or 10 into register; 12/16/24 to memory
// - long base 10 becomes 12 for register direct or immediate source, except compare, which stays at 10
// - exclusive-or into register needs data register source; 8 or 12 clocks
// - divides 162 and 144 max, multiplies 74 max, plus word ea time
// - divide reported at its worst case, within 10 percent of best
// - multiply takes 42 plus 2n clocks, n from the operand
// - signed multiply n counts bit changes in zero-prefixed 17-bit source
// - unsigned multiply n counts ones in the source
// - compare into address register 10 clocks; no byte form
// - immediate counts include immediate operand fetch
module ict_timing (
   input  wire logic                      CLK_SYS,       // 250 MHz clock
   input  wire logic                      RESETN,        // async reset, active low
   input  wire logic                      REQ_VALID,     // request strobe
   input  wire ict_pkg::ict_op_t          REQ_OP,        // instruction class
   input  wire ict_pkg::ict_size_t        REQ_SIZE,      // operand size
   input  wire ict_pkg::ict_mode_t        REQ_SRC_MODE,  // source addressing mode
   input  wire ict_pkg::ict_mode_t        REQ_DST_MODE,  // destination addressing mode
   input  wire logic [7:0]                REQ_EA_CLK,    // ea calculation clocks
   input  wire logic [3:0]                REQ_EA_RD,     // ea calculation reads
   input  wire logic [3:0]                REQ_EA_WR,     // ea calculation writes
   input  wire logic [15:0]               REQ_SRC_DATA,  // multiply source operand
   input  wire logic [7:0]                REQ_WAIT,      // wait-state clocks to add
   output logic                           RSP_VALID,     // answer strobe
   output logic [ict_pkg::CLK_W-1:0]      RSP_CLOCKS,    // total clock periods
   output logic [ict_pkg::RD_W-1:0]       RSP_READS,     // read bus cycles
   output logic [ict_pkg::WR_W-1:0]       RSP_WRITES,    // write bus cycles
   output logic                           RSP_ILLEGAL    // form does not exist
);

   // ******************************
   // state
   // ******************************
   typedef struct packed {
      logic                      valid;
      logic [ict_pkg::CLK_W-1:0] clocks;
      logic [ict_pkg::RD_W-1:0]  reads;
      logic [ict_pkg::WR_W-1:0]  writes;
      logic                      illegal;
   } ict_state_t;

   ict_state_t state_reg;
   ict_state_t state_next;

   // local widths so the size casts below stay short
   localparam int CLK_W = ict_pkg::CLK_W;
   localparam int RD_W  = ict_pkg::RD_W;
   localparam int WR_W  = ict_pkg::WR_W;

   // ******************************
   // multiply n
   // ******************************
   logic [15:0] ones_vec;
   logic [4:0]  ones_cnt;

   // signed: compare each bit of {0,src} with its upper neighbour
   always_comb
   begin
      if (REQ_OP == ict_pkg::OP_SMUL)
         ones_vec = {1'b0, REQ_SRC_DATA[15:1]} ^ REQ_SRC_DATA;
      else
         ones_vec = REQ_SRC_DATA;
   end

   ict_ones #(
      .W     (16)
   ) u_ones (
      .vec   (ones_vec),
      .count (ones_cnt)
   );

   // ******************************
   // count calculation
   // ******************************
   // one cycle of latency keeps the long mux chain off the answer path
   always_comb
   begin
      logic [ict_pkg::CLK_W-1:0] clk_v;
      logic [ict_pkg::RD_W-1:0]  rd_v;
      logic [ict_pkg::WR_W-1:0]  wr_v;
      logic                      add_ea;
      logic                      bad;
      logic                      src_reg;
      logic                      dst_mem;
      clk_v   = '0;
      rd_v    = '0;
      wr_v    = '0;
      add_ea  = 1'b1;
      bad     = 1'b0;
      src_reg = (REQ_SRC_MODE == ict_pkg::M_DATA_REG) || (REQ_SRC_MODE == ict_pkg::M_ADDR_REG)
                || (REQ_SRC_MODE == ict_pkg::M_IMMEDIATE);
      dst_mem = (REQ_DST_MODE != ict_pkg::M_DATA_REG) && (REQ_DST_MODE != ict_pkg::M_ADDR_REG);
      case (REQ_OP)
         ict_pkg::OP_MOVE_LONG:
         begin
            // both indexed modes share one entry, so index size is irrelevant
            clk_v  = CLK_W'(ict_pkg::MOVL_SRC_CLK[REQ_SRC_MODE])
                     + CLK_W'(ict_pkg::MOVL_DST_CLK[REQ_DST_MODE]);
            rd_v   = RD_W'(ict_pkg::MOVL_SRC_RD[REQ_SRC_MODE])
                     + RD_W'(ict_pkg::MOVL_DST_RD[REQ_DST_MODE]);
            wr_v   = WR_W'(ict_pkg::MOVL_DST_WR[REQ_DST_MODE]);
            add_ea = 1'b0;
         end
         ict_pkg::OP_ADD, ict_pkg::OP_AND, ict_pkg::OP_OR, ict_pkg::OP_SUB,
         ict_pkg::OP_EXCL_OR, ict_pkg::OP_COMPARE:
         begin
            rd_v = RD_W'(ict_pkg::STD_RD);
            if (dst_mem)
            begin
               // compare only reads, so it has no memory-destination form
               bad = (REQ_OP == ict_pkg::OP_COMPARE);
               case (REQ_SIZE)
                  ict_pkg::SZ_BYTE:
                  begin
                     clk_v = CLK_W'(ict_pkg::MEM_B_CLK);
                     wr_v  = WR_W'(ict_pkg::MEM_B_WR);
                  end
                  ict_pkg::SZ_WORD:
                  begin
                     clk_v = CLK_W'(ict_pkg::MEM_W_CLK);
                     wr_v  = WR_W'(ict_pkg::MEM_W_WR);
                  end
                  default:
                  begin
                     clk_v = CLK_W'(ict_pkg::MEM_L_CLK);
                     wr_v  = WR_W'(ict_pkg::MEM_L_WR);
                  end
               endcase
            end
            else if (REQ_DST_MODE == ict_pkg::M_ADDR_REG)
               bad = 1'b1;
            else if (REQ_OP == ict_pkg::OP_EXCL_OR)
            begin
               bad   = (REQ_SRC_MODE != ict_pkg::M_DATA_REG);
               clk_v = (REQ_SIZE == ict_pkg::SZ_LONG) ? CLK_W'(ict_pkg::EXCL_OR_L_CLK)
                       : CLK_W'(ict_pkg::STD_REG_BW_CLK);
            end
            else if (REQ_SIZE != ict_pkg::SZ_LONG)
               clk_v = CLK_W'(ict_pkg::STD_REG_BW_CLK);
            else if (src_reg && (REQ_OP != ict_pkg::OP_COMPARE))
               clk_v = CLK_W'(ict_pkg::STD_REG_L_EXT);
            else
               clk_v = CLK_W'(ict_pkg::STD_REG_L_CLK);
            if (REQ_SIZE == ict_pkg::SZ_BYTE && REQ_SRC_MODE == ict_pkg::M_ADDR_REG)
               bad = 1'b1;
         end
         ict_pkg::OP_COMPARE_ADDR:
         begin
            bad   = (REQ_SIZE == ict_pkg::SZ_BYTE);
            clk_v = CLK_W'(ict_pkg::CMPA_CLK);
            rd_v  = RD_W'(ict_pkg::STD_RD);
         end
         ict_pkg::OP_SMUL, ict_pkg::OP_UMUL:
         begin
            clk_v = CLK_W'(ict_pkg::MUL_BASE_CLK) + CLK_W'({ones_cnt, 1'b0});
            rd_v  = RD_W'(ict_pkg::STD_RD);
         end
         ict_pkg::OP_SDIV:
         begin
            // data-dependent spread is under 10 percent, so worst case stands
            clk_v = CLK_W'(ict_pkg::SDIV_MAX_CLK);
            rd_v  = RD_W'(ict_pkg::STD_RD);
         end
         ict_pkg::OP_UDIV:
         begin
            clk_v = CLK_W'(ict_pkg::UDIV_MAX_CLK);
            rd_v  = RD_W'(ict_pkg::STD_RD);
         end
         default:
         begin
            bad    = 1'b1;
            add_ea = 1'b0;
         end
      endcase
      // ea figures for an immediate source already hold the operand fetch
      if (add_ea)
      begin
         clk_v = clk_v + CLK_W'(REQ_EA_CLK);
         rd_v  = rd_v + RD_W'(REQ_EA_RD);
         wr_v  = wr_v + WR_W'(REQ_EA_WR);
      end
      clk_v = clk_v + CLK_W'(REQ_WAIT);
      state_next = state_reg;
      state_next.valid = REQ_VALID;
      if (REQ_VALID)
      begin
         state_next.clocks  = bad ? '0 : clk_v;
         state_next.reads   = bad ? '0 : rd_v;
         state_next.writes  = bad ? '0 : wr_v;
         state_next.illegal = bad;
      end
   end

   // ******************************
   // registers
   // ******************************
   always_ff @(posedge CLK_SYS or negedge RESETN)
   begin
      if (!RESETN)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   // answer outputs straight from flops
   assign RSP_VALID   = state_reg.valid;
   assign RSP_CLOCKS  = state_reg.clocks;
   assign RSP_READS   = state_reg.reads;
   assign RSP_WRITES  = state_reg.writes;
   assign RSP_ILLEGAL = state_reg.illegal;

endmodule // ict_timing

// *** ict_timing_asserts.sv ***
// concurrent checks on the ports of the cycle count calculator
module ict_checker (
   input wire logic                      CLK_SYS,      // clock
   input wire logic                      RESETN,       // async reset, low
   input wire logic                      REQ_VALID,    // request
   input wire ict_pkg::ict_op_t          REQ_OP,       // class
   input wire ict_pkg::ict_size_t        REQ_SIZE,     // size
   input wire ict_pkg::ict_mode_t        REQ_SRC_MODE, // source mode
   input wire ict_pkg::ict_mode_t        REQ_DST_MODE, // destination mode
   input wire logic [7:0]                REQ_EA_CLK,   // ea clocks
   input wire logic [15:0]               REQ_SRC_DATA, // multiply operand
   input wire logic [7:0]                REQ_WAIT,     // wait clocks
   input wire logic                      RSP_VALID,    // answer
   input wire logic [ict_pkg::CLK_W-1:0] RSP_CLOCKS,   // clocks
   input wire logic [ict_pkg::RD_W-1:0]  RSP_READS,    // reads
   input wire logic [ict_pkg::WR_W-1:0]  RSP_WRITES,   // writes
   input wire logic                      RSP_ILLEGAL   // no such form
);
   // bare request: no ea time and no wait states, so base figures show alone
   wire        q     = REQ_VALID && REQ_EA_CLK == 8'h00 && REQ_WAIT == 8'h00;
   wire [15:0] flips = {1'b0, REQ_SRC_DATA[15:1]} ^ REQ_SRC_DATA; // bit-pair changes
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   a_answer_next: assert property (REQ_VALID |=> RSP_VALID)
      else $error("answer missing after request");
   a_no_stray: assert property (!REQ_VALID |=> !RSP_VALID)
      else $error("answer without request");
   a_counts_hold: assert property (!RSP_VALID |-> $stable(RSP_CLOCKS) && $stable(RSP_READS))
      else $error("counts moved without answer");
   a_move_abs: assert property (q && REQ_OP == ict_pkg::OP_MOVE_LONG &&
      REQ_SRC_MODE == ict_pkg::M_ABS_LONG && REQ_DST_MODE == ict_pkg::M_ABS_LONG
      |=> RSP_CLOCKS == 10'h048 && RSP_READS == 6'h0E && RSP_WRITES == 5'h04)
      else $error("long absolute move count wrong");
   a_umul_ones: assert property (q && REQ_OP == ict_pkg::OP_UMUL |=>
      RSP_CLOCKS == 10'h02A + 10'(2 * $countones($past(REQ_SRC_DATA))))
      else $error("unsigned multiply count wrong");
   a_smul_flips: assert property (q && REQ_OP == ict_pkg::OP_SMUL |=>
      RSP_CLOCKS == 10'h02A + 10'(2 * $countones($past(flips))))
      else $error("signed multiply count wrong");
   a_sdiv_max: assert property (q && REQ_OP == ict_pkg::OP_SDIV |=> RSP_CLOCKS == 10'h0A2)
      else $error("signed divide count wrong");
   a_wait_adds: assert property (REQ_VALID && REQ_OP == ict_pkg::OP_ADD &&
      REQ_SIZE == ict_pkg::SZ_WORD && REQ_SRC_MODE == ict_pkg::M_DATA_REG &&
      REQ_DST_MODE == ict_pkg::M_DATA_REG && REQ_EA_CLK == 8'h00
      |=> RSP_CLOCKS == 10'h008 + $past(REQ_WAIT))
      else $error("wait clocks not added");
   a_eor_source: assert property (REQ_VALID && REQ_OP == ict_pkg::OP_EXCL_OR &&
      REQ_DST_MODE == ict_pkg::M_DATA_REG && REQ_SRC_MODE != ict_pkg::M_DATA_REG
      |=> RSP_ILLEGAL) else $error("exclusive-or source accepted");
   a_cmp_nomem: assert property (REQ_VALID && REQ_OP == ict_pkg::OP_COMPARE &&
      !(REQ_DST_MODE inside {ict_pkg::M_DATA_REG, ict_pkg::M_ADDR_REG})
      |=> RSP_ILLEGAL && RSP_CLOCKS == 10'h000) else $error("compare to memory accepted");
endmodule // ict_checker

bind ict_timing ict_checker chk_u (.*);

// *** ict_timing_tb.sv ***
// self-checking testbench for the cycle count calculator
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk_sys   = 1'b0;
   logic                 resetn    = 1'b0;
   logic                 req_valid = 1'b0;
   ict_pkg::ict_op_t     op        = ict_pkg::OP_ADD;
   ict_pkg::ict_size_t   size      = ict_pkg::SZ_BYTE;
   ict_pkg::ict_mode_t   src       = ict_pkg::M_DATA_REG;
   ict_pkg::ict_mode_t   dst       = ict_pkg::M_DATA_REG;
   logic [7:0]           ea_clk    = 8'h00;
   logic [7:0]           wt        = 8'h00;
   logic [3:0]           ea_rd     = 4'h0;
   logic [3:0]           ea_wr     = 4'h0;
   logic [15:0]          data      = 16'h0000;
   logic                 rsp_valid;
   logic                 rsp_illegal;
   logic [9:0]           rsp_clocks;
   logic [5:0]           rsp_reads;
   logic [4:0]           rsp_writes;
   int                   err_count = 0;
   int                   n_checks  = 0;
   always #2 clk_sys = ~clk_sys; // 250 MHz
   ict_timing dut_u (
      .CLK_SYS(clk_sys), .RESETN(resetn), .REQ_VALID(req_valid), .REQ_OP(op),
      .REQ_SIZE(size), .REQ_SRC_MODE(src), .REQ_DST_MODE(dst), .REQ_EA_CLK(ea_clk),
      .REQ_EA_RD(ea_rd), .REQ_EA_WR(ea_wr), .REQ_SRC_DATA(data), .REQ_WAIT(wt),
      .RSP_VALID(rsp_valid), .RSP_CLOCKS(rsp_clocks), .RSP_READS(rsp_reads),
      .RSP_WRITES(rsp_writes), .RSP_ILLEGAL(rsp_illegal)
   ); // ict_timing
   // ********
   // shared tasks
   // ********
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   // codes are enum positions; the answer is registered at the taking edge and checked 1 ns later
   task automatic run(logic [3:0] o, s, sm, dm, logic [7:0] ec, logic [3:0] er,
         logic [15:0] d, logic [9:0] ck, logic [5:0] rd, logic [4:0] wr, logic il);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      op <= ict_pkg::ict_op_t'(o);
      size <= ict_pkg::ict_size_t'(s[1:0]);
      src <= ict_pkg::ict_mode_t'(sm);
      dst <= ict_pkg::ict_mode_t'(dm);
      ea_clk <= ec;
      ea_rd <= er;
      data <= d;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      #1;
      chk("valid", rsp_valid, 16'h0001);
      chk("clocks", rsp_clocks, ck);
      chk("reads", rsp_reads, rd);
      chk("writes", rsp_writes, wr);
      chk("illegal", rsp_illegal, il);
   endtask
   // ********
   // scenarios
   // ********
   task automatic t_move;
      run(0, 2, 0, 0, 4, 1, 0, 8, 2, 0, 0);
      run(0, 2, 1, 2, 0, 0, 0, 24, 2, 4, 0);
      run(0, 2, 8, 8, 0, 0, 0, 72, 14, 4, 0);
      run(0, 2, 6, 5, 0, 0, 0, 58, 10, 4, 0);
      run(0, 2, 10, 6, 0, 0, 0, 60, 10, 4, 0);
   endtask
   task automatic t_std;
      for (int i = 1; i < 5; i++)
         run(i, 0, 0, 0, 0, 0, 0, 8, 2, 0, 0);
      run(2, 1, 2, 0, 4, 1, 0, 12, 3, 0, 0);
      run(3, 2, 2, 0, 6, 1, 0, 16, 3, 0, 0);
      run(4, 2, 0, 0, 0, 0, 0, 12, 2, 0, 0);
      run(1, 2, 11, 0, 4, 1, 0, 16, 3, 0, 0);
      run(1, 0, 0, 2, 4, 1, 0, 16, 3, 1, 0);
      run(2, 1, 0, 3, 4, 1, 0, 20, 3, 2, 0);
      run(4, 2, 0, 4, 6, 1, 0, 30, 3, 4, 0);
   endtask
   task automatic t_eor_cmp;
      run(5, 1, 0, 0, 0, 0, 0, 8, 2, 0, 0);
      run(5, 2, 0, 0, 0, 0, 0, 12, 2, 0, 0);
      run(5, 2, 2, 0, 4, 1, 0, 0, 0, 0, 1);
      run(7, 1, 2, 1, 4, 1, 0, 14, 3, 0, 0);
      run(7, 2, 0, 1, 0, 0, 0, 10, 2, 0, 0);
      run(6, 1, 0, 2, 4, 1, 0, 0, 0, 0, 1);
      run(6, 2, 0, 0, 0, 0, 0, 10, 2, 0, 0);
      run(1, 0, 1, 0, 0, 0, 0, 0, 0, 0, 1);
   endtask
   // worst signed pattern alternates from the top; a zero is prefixed first
   task automatic t_mul_div;
      run(9, 1, 0, 0, 0, 0, 16'hFFFF, 74, 2, 0, 0);
      run(9, 1, 0, 0, 0, 0, 16'h0000, 42, 2, 0, 0);
      run(9, 1, 0, 0, 0, 0, 16'h0F0F, 58, 2, 0, 0);
      run(8, 1, 0, 0, 0, 0, 16'hAAAA, 74, 2, 0, 0);
      run(8, 1, 0, 0, 0, 0, 16'h8000, 46, 2, 0, 0);
      run(8, 1, 2, 0, 8, 2, 16'h0001, 52, 4, 0, 0);
      run(10, 1, 0, 0, 0, 0, 16'h0001, 162, 2, 0, 0);
      run(10, 1, 0, 0, 0, 0, 16'hFFFF, 162, 2, 0, 0);
      run(11, 1, 2, 0, 4, 1, 0, 148, 3, 0, 0);
   endtask
   task automatic t_wait;
      @(posedge clk_sys);
      wt <= 8'h03;
      ea_wr <= 4'h1;
      run(1, 0, 0, 2, 4, 1, 0, 19, 3, 2, 0);
      run(0, 2, 8, 8, 0, 0, 0, 75, 14, 4, 0);
      run(1, 1, 0, 0, 0, 0, 0, 11, 2, 1, 0);
      wt <= 8'h00;
      ea_wr <= 4'h0;
   endtask
   // reset in mid-run clears the held counts at once and keeps them clear
   task automatic t_reset;
      run(9, 1, 0, 0, 0, 0, 16'h00FF, 58, 2, 0, 0);
      @(posedge clk_sys);
      resetn <= 1'b0;
      #1;
      chk("reset clocks", rsp_clocks, 16'h0000);
      chk("reset reads", rsp_reads, 16'h0000);
      @(posedge clk_sys);
      resetn <= 1'b1;
      #1;
      chk("released valid", rsp_valid, 16'h0000);
      chk("released clocks", rsp_clocks, 16'h0000);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // reset, idle outputs, then every scenario in turn
   initial
   begin
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      #1;
      chk("idle valid", rsp_valid, 16'h0000);
      chk("idle clocks", rsp_clocks, 16'h0000);
      t_move;
      t_std;
      t_eor_cmp;
      t_mul_div;
      t_wait;
      t_reset;
      report_and_stop;
   end
endmodule // testbench
